// ---- core/multiplier_contention_interlock.sv ----
// Notes on behaviour
// - word multiply reaches multiplier in its access stage
// - word multiply leaves multiplier busy two cycles
// - back-to-back multiply access waits, one slot
// - spaced multiplier instructions pass without stall
// - multiply access meeting fetch splits the slot
// - double-length after word multiply never stalls
// - accumulator-to-register move gets multiplier access stage
// - accumulator store: one stage reads, writes memory
// - accumulator store stage contends with fetch
// - register-to-accumulator load waits, contends with fetch
// - memory-to-accumulator load waits, contends with fetch
// - double-length: two access stages, second uses multiplier
// - double-length leaves multiplier busy four cycles
// - decode after double-length stalls one slot
// - both double-length access stages split on fetch
// - no extra stall when follower ignores multiplier
// - multiplier users after double-length are interlocked
`timescale 1ns/10ps
module multiplier_contention_interlock
(
    input  wire logic                            clock_i,
    input  wire logic                            rstn_i,
    input  mult_interlock_pkg::ma_req_type       ma_req_i,
    input  wire logic                            fetch_req_i,
    input  mult_interlock_pkg::decode_req_type   decode_req_i,
    output logic                                 ma_done_o,
    output logic                                 ma_hold_o,
    output logic                                 mult_access_o,
    output logic                                 fetch_grant_o,
    output logic                                 slot_end_o,
    output logic                                 decode_stall_o,
    output logic                                 illegal_o,
    output logic                                 busy_o,
    output logic [2:0]                           busy_count_o,
    output logic [7:0]                           extend_count_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    mult_interlock_pkg::ma_class_type   ma_class;
    mult_interlock_pkg::slot_state_type state;
    mult_interlock_pkg::slot_state_type next_state;

    logic       next_ma_done;
    logic       next_ma_hold;
    logic       next_mult_access;
    logic       next_fetch_grant;
    logic       next_slot_end;
    logic       next_decode_stall;
    logic       next_illegal;
    logic [7:0] next_extend_count;

    logic       take_ma;
    logic       blocked;
    logic       load_busy;
    logic [2:0] counter_value;
    logic       counter_word;
    logic       counter_busy;

    // ************************************************************
    // submodules
    // ************************************************************
    op_classifier u_classifier
    (
        .ma_req_i (ma_req_i),
        .class_o  (ma_class)
    );

    mult_busy_counter u_busy
    (
        .clock_i       (clock_i),
        .rstn_i        (rstn_i),
        .load_i        (load_busy),
        .load_value_i  (ma_class.busy_load),
        .load_word_i   (ma_class.busy_word),
        .count_o       (counter_value),
        .word_source_o (counter_word),
        .busy_o        (counter_busy)
    );

    // ************************************************************
    // contention decode
    // ************************************************************
    // the cycle after a completed access is an ack cycle: the
    // requester moves on at that edge, so a still-present request
    // must not be taken twice
    assign take_ma = ma_req_i.valid && !ma_done_o
                  && (state != mult_interlock_pkg::ST_SPLIT);

    // a word multiply's busy period does not block the multiplier
    // stage of a double-length multiply or an accumulate
    assign blocked = ma_class.mult_access
                  && (counter_value != 3'h0)
                  && !(counter_word && ma_class.exempt_word);

    assign load_busy = take_ma && ma_class.legal && !blocked
                    && ma_class.mult_access;

    // ************************************************************
    // slot sequencing
    // ************************************************************
    always_comb
    begin
        next_state        = state;
        next_ma_done      = 1'b0;
        next_ma_hold      = 1'b0;
        next_mult_access  = 1'b0;
        next_fetch_grant  = 1'b0;
        next_slot_end     = 1'b0;
        next_illegal      = 1'b0;
        next_extend_count = extend_count_o;
        case (state)
            mult_interlock_pkg::ST_OPEN,
            mult_interlock_pkg::ST_EXTEND:
            begin
                if (take_ma && !ma_class.legal)
                begin
                    // unknown class: finish the stage with no multiplier use
                    next_illegal     = 1'b1;
                    next_ma_done     = 1'b1;
                    next_slot_end    = 1'b1;
                    next_fetch_grant = fetch_req_i;
                    next_state       = mult_interlock_pkg::ST_OPEN;
                end
                else if (take_ma && blocked)
                begin
                    // stage stretched; the bus stays with it, fetch waits
                    next_ma_hold = 1'b1;
                    next_state   = mult_interlock_pkg::ST_EXTEND;
                    if (state == mult_interlock_pkg::ST_OPEN)
                    begin
                        next_extend_count = 8'h01;
                    end
                    else if (extend_count_o != mult_interlock_pkg::EXTEND_MAX)
                    begin
                        next_extend_count = extend_count_o + 8'h01;
                    end
                end
                else if (take_ma)
                begin
                    next_ma_done     = 1'b1;
                    next_mult_access = ma_class.mult_access;
                    if (state == mult_interlock_pkg::ST_OPEN)
                    begin
                        next_extend_count = 8'h00;
                    end
                    if (fetch_req_i && ma_class.bus_contend)
                    begin
                        // access first, fetch in a second cycle of the slot
                        next_state = mult_interlock_pkg::ST_SPLIT;
                    end
                    else
                    begin
                        next_slot_end    = 1'b1;
                        next_fetch_grant = fetch_req_i;
                        next_state       = mult_interlock_pkg::ST_OPEN;
                    end
                end
                else if (!ma_done_o)
                begin
                    // no access stage: a plain one-cycle slot
                    next_slot_end    = 1'b1;
                    next_fetch_grant = fetch_req_i;
                    next_state       = mult_interlock_pkg::ST_OPEN;
                end
                else
                begin
                    next_state = mult_interlock_pkg::ST_OPEN;
                end
            end
            mult_interlock_pkg::ST_SPLIT:
            begin
                next_fetch_grant = 1'b1;
                next_slot_end    = 1'b1;
                next_state       = mult_interlock_pkg::ST_OPEN;
            end
            default:
            begin
                next_state = mult_interlock_pkg::ST_OPEN;
            end
        endcase
    end

    // ************************************************************
    // decode stall after double-length multiply
    // ************************************************************
    // a new double-length decode wins over the slot end that clears
    // the previous one, so back-to-back stalls are never dropped
    always_comb
    begin
        next_decode_stall = decode_stall_o;
        if (decode_req_i.valid && mult_interlock_pkg::is_double_length(decode_req_i.op))
        begin
            next_decode_stall = 1'b1;
        end
        else if (next_slot_end)
        begin
            next_decode_stall = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            state          <= mult_interlock_pkg::ST_OPEN;
            ma_done_o      <= 1'b0;
            ma_hold_o      <= 1'b0;
            mult_access_o  <= 1'b0;
            fetch_grant_o  <= 1'b0;
            slot_end_o     <= 1'b0;
            decode_stall_o <= 1'b0;
            illegal_o      <= 1'b0;
            extend_count_o <= 8'h00;
        end
        else
        begin
            state          <= next_state;
            ma_done_o      <= next_ma_done;
            ma_hold_o      <= next_ma_hold;
            mult_access_o  <= next_mult_access;
            fetch_grant_o  <= next_fetch_grant;
            slot_end_o     <= next_slot_end;
            decode_stall_o <= next_decode_stall;
            illegal_o      <= next_illegal;
            extend_count_o <= next_extend_count;
        end
    end

    // busy state is held in the counter's own flops
    assign busy_o       = counter_busy;
    assign busy_count_o = counter_value;

endmodule

// ---- core/mult_interlock_pkg.sv ----
package mult_interlock_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int              CLOCK_PERIOD_NS  = 20;
    localparam int              COUNT_WIDTH      = 3;
    localparam logic [2:0]      WORD_BUSY_CYCLES = 3'h2;
    localparam logic [2:0]      LONG_BUSY_CYCLES = 3'h4;
    localparam logic [2:0]      NO_BUSY_CYCLES   = 3'h0;
    localparam int              EXTEND_WIDTH     = 8;
    localparam logic [7:0]      EXTEND_MAX       = 8'hFF;

    // ************************************************************
    // instruction classes
    // ************************************************************
    typedef enum logic [3:0]
    {
        OP_NONE                  = 4'h0,
        OP_WORD_MULTIPLY         = 4'h1,
        OP_DOUBLE_SIGNED         = 4'h2,
        OP_DOUBLE_UNSIGNED       = 4'h3,
        OP_LONG_LOW_PRODUCT      = 4'h4,
        OP_WORD_MAC              = 4'h5,
        OP_LONG_MAC              = 4'h6,
        OP_STORE_SYS             = 4'h7,
        OP_STORE_SYS_TO_MEMORY   = 4'h8,
        OP_LOAD_SYS              = 4'h9,
        OP_LOAD_SYS_FROM_MEMORY  = 4'hA
    } op_type;

    typedef enum logic [1:0]
    {
        ST_OPEN   = 2'b00,
        ST_EXTEND = 2'b01,
        ST_SPLIT  = 2'b10
    } slot_state_type;

    typedef struct packed
    {
        logic   valid;
        op_type op;
        logic   second;
    } ma_req_type;

    typedef struct packed
    {
        logic   valid;
        op_type op;
    } decode_req_type;

    typedef struct packed
    {
        logic       legal;
        logic       mult_access;
        logic       exempt_word;
        logic       bus_contend;
        logic [2:0] busy_load;
        logic       busy_word;
    } ma_class_type;

    function automatic logic is_double_length(input op_type op);
        is_double_length = (op == OP_DOUBLE_SIGNED) || (op == OP_DOUBLE_UNSIGNED)
                        || (op == OP_LONG_LOW_PRODUCT);
    endfunction

    function automatic logic has_second_ma(input op_type op);
        has_second_ma = is_double_length(op) || (op == OP_WORD_MAC) || (op == OP_LONG_MAC);
    endfunction

endpackage

// ---- core/op_classifier.sv ----
`timescale 1ns/10ps
module op_classifier
(
    input  mult_interlock_pkg::ma_req_type   ma_req_i,
    output mult_interlock_pkg::ma_class_type class_o
);

    always_comb
    begin
        class_o             = '0;
        class_o.legal       = ma_req_i.valid;
        class_o.bus_contend = 1'b1;
        class_o.busy_load   = mult_interlock_pkg::NO_BUSY_CYCLES;
        if (ma_req_i.second && !mult_interlock_pkg::has_second_ma(ma_req_i.op))
        begin
            class_o.legal = 1'b0;
        end
        case (ma_req_i.op)
            mult_interlock_pkg::OP_WORD_MULTIPLY:
            begin
                class_o.mult_access = 1'b1;
                class_o.busy_load   = mult_interlock_pkg::WORD_BUSY_CYCLES;
                class_o.busy_word   = 1'b1;
            end
            mult_interlock_pkg::OP_DOUBLE_SIGNED,
            mult_interlock_pkg::OP_DOUBLE_UNSIGNED,
            mult_interlock_pkg::OP_LONG_LOW_PRODUCT:
            begin
                // only the second access stage touches the multiplier
                class_o.mult_access = ma_req_i.second;
                class_o.exempt_word = 1'b1;
                class_o.busy_load   = ma_req_i.second ? mult_interlock_pkg::LONG_BUSY_CYCLES
                                                      : mult_interlock_pkg::NO_BUSY_CYCLES;
            end
            mult_interlock_pkg::OP_WORD_MAC,
            mult_interlock_pkg::OP_LONG_MAC:
            begin
                class_o.mult_access = ma_req_i.second;
                class_o.exempt_word = 1'b1;
            end
            mult_interlock_pkg::OP_STORE_SYS,
            mult_interlock_pkg::OP_STORE_SYS_TO_MEMORY,
            mult_interlock_pkg::OP_LOAD_SYS,
            mult_interlock_pkg::OP_LOAD_SYS_FROM_MEMORY:
            begin
                class_o.mult_access = 1'b1;
            end
            default:
            begin
                class_o.legal       = 1'b0;
                class_o.bus_contend = 1'b0;
            end
        endcase
    end

endmodule

// ---- core/mult_busy_counter.sv ----
`timescale 1ns/10ps
module mult_busy_counter
(
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       load_i,
    input  wire logic [2:0] load_value_i,
    input  wire logic       load_word_i,
    output logic [2:0]      count_o,
    output logic            word_source_o,
    output logic            busy_o
);

    logic [2:0] next_count;
    logic       next_word_source;

    // ************************************************************
    // down-counter of multiplier busy cycles
    // ************************************************************
    always_comb
    begin
        next_count       = count_o;
        next_word_source = word_source_o;
        if (load_i)
        begin
            next_count       = load_value_i;
            next_word_source = load_word_i;
        end
        else if (count_o != 3'h0)
        begin
            next_count = count_o - 3'h1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            count_o       <= 3'h0;
            word_source_o <= 1'b0;
            busy_o        <= 1'b0;
        end
        else
        begin
            count_o       <= next_count;
            word_source_o <= next_word_source;
            busy_o        <= (next_count != 3'h0);
        end
    end

endmodule

// ---- sim/fetch_model.sv ----
`timescale 1ns/10ps
module fetch_model
(
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic want_i,
    input  wire logic fetch_grant_i,
    output logic      fetch_req_o
);
    logic next_req;

    // request stays up until granted, then drops a cycle so grants pair with fetches
    always_comb next_req = fetch_req_o ? !fetch_grant_i : want_i;

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            fetch_req_o <= 1'b0;
        else
            fetch_req_o <= next_req;
    end
endmodule

// ---- sim/mult_interlock_assertions.sv ----
`timescale 1ns/10ps
module mult_interlock_assertions
(
    input  wire logic                          clock_i,
    input  wire logic                          rstn_i,
    input  mult_interlock_pkg::ma_req_type     ma_req_i,
    input  wire logic                          fetch_req_i,
    input  mult_interlock_pkg::decode_req_type decode_req_i,
    input  wire logic                          ma_done_o,
    input  wire logic                          ma_hold_o,
    input  wire logic                          mult_access_o,
    input  wire logic                          fetch_grant_o,
    input  wire logic                          slot_end_o,
    input  wire logic                          decode_stall_o,
    input  wire logic                          busy_o,
    input  wire logic [2:0]                    busy_count_o
);
    localparam mult_interlock_pkg::op_type WORD = mult_interlock_pkg::OP_WORD_MULTIPLY;
    mult_interlock_pkg::ma_req_type prev_req;
    logic                           prev_dbl;
    logic                           dec_dbl;

    // ************************************************************
    // request seen at the taking edge
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        prev_req <= rstn_i ? ma_req_i : '0;
    end

    assign prev_dbl = prev_req.second && (prev_req.op inside
        {mult_interlock_pkg::OP_DOUBLE_SIGNED, mult_interlock_pkg::OP_DOUBLE_UNSIGNED,
         mult_interlock_pkg::OP_LONG_LOW_PRODUCT});
    assign dec_dbl = decode_req_i.valid && (decode_req_i.op inside
        {mult_interlock_pkg::OP_DOUBLE_SIGNED, mult_interlock_pkg::OP_DOUBLE_UNSIGNED,
         mult_interlock_pkg::OP_LONG_LOW_PRODUCT});

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // ************************************************************
    // checks
    // ************************************************************
    word_busy_a: assert property (
        ma_done_o && prev_req.op == WORD |-> busy_count_o == 3'h2 && mult_access_o)
        else $error("word multiply did not load two busy cycles");
    word_decay_a: assert property (
        ma_done_o && prev_req.op == WORD |=> busy_count_o == 3'h1)
        else $error("word multiply busy did not count down");
    long_busy_a: assert property (
        ma_done_o && prev_dbl |-> busy_count_o == 3'h4 ##1 busy_count_o == 3'h3
        ##1 busy_count_o == 3'h2 ##1 busy_count_o == 3'h1 ##1 busy_count_o == 3'h0)
        else $error("double-length busy period wrong");
    busy_flag_a: assert property (
        busy_o == (busy_count_o != 3'h0))
        else $error("busy flag disagrees with count");
    hold_cause_a: assert property (
        ma_hold_o |-> $past(busy_count_o) != 3'h0 && !ma_done_o)
        else $error("hold without a busy multiplier");
    hold_release_a: assert property (
        ma_hold_o && busy_count_o == 3'h0 |=> ma_done_o)
        else $error("held access not completed when busy ended");
    split_slot_a: assert property (
        ma_done_o && mult_access_o && $past(fetch_req_i) |=> fetch_grant_o && slot_end_o)
        else $error("access meeting fetch did not split the slot");
    fetch_apart_a: assert property (
        ma_done_o |-> !fetch_grant_o)
        else $error("fetch granted in the access cycle");
    done_spacing_a: assert property (
        ma_done_o |=> !ma_done_o)
        else $error("access completions back to back");
    decode_stall_a: assert property (
        dec_dbl |=> decode_stall_o)
        else $error("decode not stalled after double-length");
endmodule

bind multiplier_contention_interlock mult_interlock_assertions checker_inst
(
    .clock_i        (clock_i),
    .rstn_i         (rstn_i),
    .ma_req_i       (ma_req_i),
    .fetch_req_i    (fetch_req_i),
    .decode_req_i   (decode_req_i),
    .ma_done_o      (ma_done_o),
    .ma_hold_o      (ma_hold_o),
    .mult_access_o  (mult_access_o),
    .fetch_grant_o  (fetch_grant_o),
    .slot_end_o     (slot_end_o),
    .decode_stall_o (decode_stall_o),
    .busy_o         (busy_o),
    .busy_count_o   (busy_count_o)
);

// ---- sim/multiplier_contention_interlock_bench.sv ----
`timescale 1ns/10ps
module multiplier_contention_interlock_bench;
    typedef struct packed
    {
        logic [3:0] op;
        logic       second;
        logic [2:0] count;
        logic       macc;
    } row_type;

    logic                               clock_i;
    logic                               rstn_i;
    mult_interlock_pkg::ma_req_type     ma_req;
    mult_interlock_pkg::decode_req_type decode_req;
    logic                               want, fetch_req, ma_done, ma_hold, mult_access;
    logic                               fetch_grant, slot_end, decode_stall, illegal, busy;
    logic [2:0]                         busy_count, done_count;
    logic [7:0]                         extend_count, holds;
    logic                               done_macc;
    logic                               done_illegal;
    int                                 num_errors = 0;
    int                                 check_count = 0;
    logic [3:0]                         users [5] = '{4'h1, 4'h7, 4'h8, 4'h9, 4'hA};
    row_type                            rows [12] = '{
        '{4'h1, 1'b0, 3'h2, 1'b1}, '{4'h2, 1'b0, 3'h0, 1'b0}, '{4'h2, 1'b1, 3'h4, 1'b1},
        '{4'h3, 1'b1, 3'h4, 1'b1}, '{4'h4, 1'b1, 3'h4, 1'b1}, '{4'h5, 1'b0, 3'h0, 1'b0},
        '{4'h5, 1'b1, 3'h0, 1'b1}, '{4'h6, 1'b1, 3'h0, 1'b1}, '{4'h7, 1'b0, 3'h0, 1'b1},
        '{4'h8, 1'b0, 3'h0, 1'b1}, '{4'h9, 1'b0, 3'h0, 1'b1}, '{4'hA, 1'b0, 3'h0, 1'b1}};

    multiplier_contention_interlock dut
    (
        .clock_i        (clock_i),
        .rstn_i         (rstn_i),
        .ma_req_i       (ma_req),
        .fetch_req_i    (fetch_req),
        .decode_req_i   (decode_req),
        .ma_done_o      (ma_done),
        .ma_hold_o      (ma_hold),
        .mult_access_o  (mult_access),
        .fetch_grant_o  (fetch_grant),
        .slot_end_o     (slot_end),
        .decode_stall_o (decode_stall),
        .illegal_o      (illegal),
        .busy_o         (busy),
        .busy_count_o   (busy_count),
        .extend_count_o (extend_count)
    );

    fetch_model fetcher
    (
        .clock_i       (clock_i),
        .rstn_i        (rstn_i),
        .want_i        (want),
        .fetch_grant_i (fetch_grant),
        .fetch_req_o   (fetch_req)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #(mult_interlock_pkg::CLOCK_PERIOD_NS / 2) clock_i = ~clock_i;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // called at a rising edge; returns at the edge after completion
    task automatic issue(input logic [3:0] op, input logic second);
        int n;
        n = 0;
        holds = 8'h00;
        ma_req <= '{1'b1, mult_interlock_pkg::op_type'(op), second};
        do
        begin
            @(posedge clock_i);
            #1;
            holds = holds + 8'(ma_hold === 1'b1);
            n++;
        end while (ma_done !== 1'b1 && n < 20);
        check(8'(ma_done), 8'h01, "access completion");
        done_count = busy_count;
        done_macc = mult_access;
        done_illegal = illegal;
        @(posedge clock_i);
    endtask

    // six cycles outlast the longest busy period
    task automatic idle;
        ma_req <= '0;
        repeat (6) @(posedge clock_i);
    endtask

    task automatic results;
        $display("mismatches %0d, comparisons %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #(4000 * mult_interlock_pkg::CLOCK_PERIOD_NS);
        num_errors++;
        results();
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        rstn_i = 1'b0;
        ma_req = '0;
        decode_req = '0;
        want = 1'b0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        check({5'h00, busy_count}, 8'h00, "count in reset");
        check({6'h00, ma_done, decode_stall}, 8'h00, "outputs in reset");
        repeat (2) @(posedge clock_i);
        want <= 1'b1;
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].second);
            check({5'h00, done_count}, {5'h00, rows[i].count}, "busy load");
            check(8'(done_macc), 8'(rows[i].macc), "multiplier access");
            check(8'(done_illegal), 8'h00, "legal class flagged");
            idle();
        end
        want <= 1'b0;
        issue(4'h1, 1'b0);
        issue(4'h1, 1'b0);
        check(holds, 8'h01, "back to back hold");
        idle();
        issue(4'h1, 1'b0);
        ma_req <= '0;
        @(posedge clock_i);
        issue(4'h1, 1'b0);
        check(holds, 8'h00, "spaced hold");
        issue(4'h2, 1'b0);
        issue(4'h2, 1'b1);
        check(holds, 8'h00, "double after word");
        idle();
        foreach (users[i])
        begin
            issue(4'h2, 1'b0);
            issue(4'h2, 1'b1);
            issue(users[i], 1'b0);
            check(holds, 8'h03, "user after double");
            check(extend_count, 8'h03, "extension");
            idle();
        end
        issue(4'h0, 1'b0);
        check(8'(done_illegal), 8'h01, "unknown class not flagged");
        check(8'(done_macc), 8'h00, "unknown class used multiplier");
        idle();
        decode_req <= '{1'b1, mult_interlock_pkg::OP_DOUBLE_SIGNED};
        @(posedge clock_i);
        decode_req <= '0;
        #1;
        check(8'(decode_stall), 8'h01, "stall after double");
        repeat (4) @(posedge clock_i);
        check(8'(decode_stall), 8'h00, "stall one slot");
        decode_req <= '{1'b1, mult_interlock_pkg::OP_WORD_MULTIPLY};
        @(posedge clock_i);
        decode_req <= '0;
        #1;
        check(8'(decode_stall), 8'h00, "no stall after word");
        results();
    end
endmodule
